// ### core/fll_clock_generator_consts.svh
// Register indices, reset values and fixed codes of the clock generator
`ifndef FLL_CLOCK_GENERATOR_CONSTS_SVH
`define FLL_CLOCK_GENERATOR_CONSTS_SVH
// Register indices; the APB byte address is four times the index
`define IDX_INT_LOW   7'h50
`define IDX_INT_HIGH  7'h51
`define IDX_MULT      7'h52
`define IDX_CTL0      7'h53
`define IDX_CTL1      7'h54
`define IDX_INT_EN    7'h00
`define IDX_INT_FLAG  7'h02
`define IDX_OP_MODE   7'h55
// Reset values of the fields
`define RST_MULT_N    7'h1F
`define RST_MOD_CTL   1'h0
`define RST_LOOP_DIV  2'h1
`define RST_RANGE     4'h0
`define RST_LOAD_CAP  2'h0
`define RST_SECOND_OFF 1'h1
`define RST_INTEG     10'h000
// Bit positions inside written bytes
`define BIT_FAULT     1
`define BIT_HALT      0
`define BIT_SUBGEN    1
`define BIT_CRYSTAL_OSC_DISABLE    2
`define BIT_CPU_CLOCK_OFF    3
// Main clock source codes
`define MAIN_SECOND   2'h2
`define MAIN_PRIMARY  2'h3
// Tap codes
`define TAP_TOP       5'h1C
`define TAP_ALL_SET   5'h1F
`define TAP_LOWEST    5'h00
`endif

// ### core/fll_pkg.sv
// Types shared by the clock generator and its bench
package fll_pkg;
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;
   typedef struct packed {
      logic auxCrystal;
      logic secondCrystal;
      logic ctrlOsc;
      logic primaryOk;
      logic secondOk;
   } pin_in_t;
   typedef struct packed {
      logic mainClock;
      logic subMainClock;
      logic auxClock;
      logic auxOutClock;
      logic ctrlOscClock;
   } clocks_t;
   typedef enum logic [2:0] {
      SRC_DCO     = 3'b001,
      SRC_SECOND  = 3'b010,
      SRC_PRIMARY = 3'b100
   } src_t;
endpackage

// ### core/fll_clock_generator.sv
// Frequency-locked loop clock generator with APB register file
`timescale 1ns/100ps
`include "fll_clock_generator_consts.svh"
module fll_clock_generator #(
   parameter int AuxLostCycles = 8192
) (
   input  wire  logic             clock,
   input  wire  logic             reset_n,
   input  wire  fll_pkg::apb_req_t apbIn,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire  fll_pkg::pin_in_t pinIn,
   input  wire  logic             interruptEntry,
   input  wire  logic             nmiGrant,
   output fll_pkg::clocks_t       clocksOut,
   output logic                   nmiRequest,
   output logic                   primaryOscEnable,
   output logic                   secondOscEnable,
   output logic                   crystalSpeed,
   output logic [1:0]             loadCap,
   output logic [4:0]             tapSelect,
   output logic [2:0]             oscRange
);
   import fll_pkg::*;

   logic [1:0] rstSync_q;
   logic       rstN;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) rstSync_q <= 2'h0;
      else rstSync_q <= {rstSync_q[0], 1'b1};
   end
   assign rstN = rstSync_q[1];

   // Pin synchronisers; only the second stage and later are read
   logic [4:0] pinRaw, sync1_q, lvl_q, prv_q;
   assign pinRaw = pinIn;
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         always_ff @(posedge clock or negedge rstN) begin
            if (!rstN) begin
               sync1_q[gi] <= 1'b0;
               lvl_q[gi]   <= 1'b0;
               prv_q[gi]   <= 1'b0;
            end else begin
               sync1_q[gi] <= pinRaw[gi];
               lvl_q[gi]   <= sync1_q[gi];
               prv_q[gi]   <= lvl_q[gi];
            end
         end
      end
   endgenerate
   wire auxLvl    = lvl_q[4];
   wire secondLvl = lvl_q[3];
   wire dcoLvl    = lvl_q[2];
   wire primOk    = lvl_q[1];
   wire secOk     = lvl_q[0];
   wire auxRise   = lvl_q[4] & ~prv_q[4];
   wire dcoRise   = lvl_q[2] & ~prv_q[2];

   function automatic logic [4:0] clampTap(input logic [5:0] t);
      clampTap = (t > {1'b0, `TAP_TOP}) ? `TAP_TOP : t[4:0];
   endfunction

   // APB slave: one wait state, answer in the second access cycle
   logic        pready_q, pslverr_q;
   logic [31:0] prdata_q;
   wire [6:0] idx = apbIn.paddr[8:2];
   wire addrOk = (apbIn.paddr[11:9] == 3'h0) && (apbIn.paddr[1:0] == 2'h0);
   wire access = apbIn.psel & apbIn.penable;
   wire setupAcc = access & ~pready_q;
   wire wrEn = access & pready_q & apbIn.pwrite & addrOk;
   wire [7:0] wd = apbIn.pwdata[7:0];
   wire wIntL = wrEn & (idx == `IDX_INT_LOW);
   wire wIntH = wrEn & (idx == `IDX_INT_HIGH);
   wire wMult = wrEn & (idx == `IDX_MULT);
   wire wCtl0 = wrEn & (idx == `IDX_CTL0);
   wire wCtl1 = wrEn & (idx == `IDX_CTL1);
   wire wIe   = wrEn & (idx == `IDX_INT_EN);
   wire wIfg  = wrEn & (idx == `IDX_INT_FLAG);
   wire wMode = wrEn & (idx == `IDX_OP_MODE);

   // Configuration fields
   logic [6:0] multN_q;
   logic       modCtl_q, prediv_q, speed_q, secondOff_q, subDis_q, subSrc_q;
   logic [1:0] loopDiv_q, loadCap_q, mainSrc_q, auxDiv_q;
   logic [3:0] range_q;
   logic       loopHalt_q, subGen_q, crystal_osc_disable_q, cpu_clock_off_q, intEn_q;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         multN_q     <= `RST_MULT_N;
         modCtl_q    <= `RST_MOD_CTL;
         loopDiv_q   <= `RST_LOOP_DIV;
         range_q     <= `RST_RANGE;
         prediv_q    <= 1'b0;
         speed_q     <= 1'b0;
         loadCap_q   <= `RST_LOAD_CAP;
         secondOff_q <= `RST_SECOND_OFF;
         subDis_q    <= 1'b0;
         mainSrc_q   <= 2'h0;
         subSrc_q    <= 1'b0;
         auxDiv_q    <= 2'h0;
      end else begin
         if (wMult) {modCtl_q, multN_q} <= wd;
         if (wIntL) {loopDiv_q, range_q} <= wd[7:2];
         if (wCtl0) {prediv_q, speed_q, loadCap_q} <= wd[7:4];
         if (wCtl1) {subDis_q, secondOff_q, mainSrc_q, subSrc_q, auxDiv_q} <= wd[6:0];
      end
   end

   // Interrupt entry wins over a software write to the same bits
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         loopHalt_q <= 1'b0;
         subGen_q   <= 1'b0;
         crystal_osc_disable_q   <= 1'b0;
         cpu_clock_off_q   <= 1'b0;
         intEn_q    <= 1'b0;
      end else begin
         if (wMode) loopHalt_q <= wd[`BIT_HALT];
         subGen_q <= ~interruptEntry & (wMode ? wd[`BIT_SUBGEN] : subGen_q);
         crystal_osc_disable_q <= ~interruptEntry & (wMode ? wd[`BIT_CRYSTAL_OSC_DISABLE] : crystal_osc_disable_q);
         cpu_clock_off_q <= ~interruptEntry & (wMode ? wd[`BIT_CPU_CLOCK_OFF] : cpu_clock_off_q);
         intEn_q  <= ~nmiGrant & (wIe ? wd[`BIT_FAULT] : intEn_q);
      end
   end

   // Oscillator enables
   wire primaryEn = ~(crystal_osc_disable_q & ((mainSrc_q != `MAIN_PRIMARY) | cpu_clock_off_q));
   wire secondEn = ~(secondOff_q & ((mainSrc_q != `MAIN_SECOND) | cpu_clock_off_q)
                     & (~subSrc_q | subDis_q));

   // Loop feedback: count fDCO/D edges per aux period
   logic [2:0] divCnt_q;
   logic [8:0] fbCnt_q;
   logic [9:0] integ_q, integ_d;
   logic [15:0] lostCnt_q;
   wire [2:0] divMask = ~(3'h7 << loopDiv_q);
   wire divMatch = (divCnt_q & divMask) == divMask;
   wire [8:0] target = {2'h0, multN_q} + 9'h001;
   wire lostTick = (lostCnt_q == 16'(AuxLostCycles - 1));
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         divCnt_q  <= 3'h0;
         fbCnt_q   <= 9'h000;
         lostCnt_q <= 16'h0000;
      end else begin
         if (dcoRise) divCnt_q <= divCnt_q + 3'h1;
         if (auxRise) fbCnt_q <= 9'h000;
         else if (dcoRise & divMatch & (fbCnt_q != 9'h1FF)) fbCnt_q <= fbCnt_q + 9'h001;
         if (auxRise | lostTick) lostCnt_q <= 16'h0000;
         else lostCnt_q <= lostCnt_q + 16'h0001;
      end
   end

   // Integrator: software write wins over the hardware step
   wire stepUp = auxRise & (fbCnt_q < target) & (integ_q != 10'h3FF);
   wire stepDn = ((auxRise & (fbCnt_q > target)) | lostTick) & (integ_q != 10'h000);
   always_comb begin
      integ_d = integ_q;
      if (wIntL | wIntH) begin
         if (wIntL) integ_d[1:0] = wd[1:0];
         if (wIntH) integ_d[9:2] = wd;
      end else if (!loopHalt_q) begin
         if (stepUp) integ_d = integ_q + 10'h001;
         else if (stepDn) integ_d = integ_q - 10'h001;
      end
   end
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) integ_q <= `RST_INTEG;
      else integ_q <= integ_d;
   end
   wire [4:0] tapCode = integ_q[9:5];
   wire [4:0] modCode = integ_q[4:0];

   // Modulator: carry of a 5-bit accumulator picks the upper tap
   logic [4:0] modAcc_q, tapSel_q;
   wire [5:0] accSum = {1'b0, modAcc_q} + {1'b0, modCode};
   wire upper = modCtl_q ? accSum[5] : modCode[4];
   wire [4:0] tapNext = clampTap({1'b0, tapCode} + {5'h00, upper});
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         modAcc_q <= 5'h00;
         tapSel_q <= `TAP_LOWEST;
      end else if (dcoRise) begin
         modAcc_q <= modCtl_q ? accSum[4:0] : 5'h00;
         tapSel_q <= tapNext;
      end
   end

   // Faults
   logic lfFault_q, hfFault_q, secFault_q, dcoFault_q, faultFlag_q;
   wire anyFault = lfFault_q | hfFault_q | secFault_q | dcoFault_q;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         lfFault_q   <= 1'b1;
         hfFault_q   <= 1'b0;
         secFault_q  <= 1'b0;
         dcoFault_q  <= 1'b1;
         faultFlag_q <= 1'b1;
      end else begin
         lfFault_q   <= primaryEn & ~speed_q & ~primOk;
         hfFault_q   <= primaryEn & speed_q & ~primOk;
         secFault_q  <= secondEn & ~secOk;
         dcoFault_q  <= (tapCode == `TAP_LOWEST) | (tapCode == `TAP_ALL_SET);
         faultFlag_q <= anyFault | (wIfg ? wd[`BIT_FAULT] : faultFlag_q);
      end
   end

   // Clock division
   logic [2:0] auxCnt_q;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) auxCnt_q <= 3'h0;
      else if (auxRise) auxCnt_q <= auxCnt_q + 3'h1;
   end
   wire ctrlDiv = (loopDiv_q == 2'h0) ? dcoLvl : divCnt_q[loopDiv_q - 2'h1];
   wire ctrlClk = prediv_q ? dcoLvl : ctrlDiv;
   wire auxOut = (auxDiv_q == 2'h0) ? auxLvl : auxCnt_q[auxDiv_q - 2'h1];

   // Glitch-free selection: switch only while old and new levels are both low
   function automatic logic srcLevel(input src_t s, input logic d, input logic x2, input logic x1);
      srcLevel = (s == SRC_DCO) ? d : ((s == SRC_SECOND) ? x2 : x1);
   endfunction
   src_t mainCur_q, subCur_q;
   wire src_t mainWant = faultFlag_q ? SRC_DCO :
                         (mainSrc_q == `MAIN_SECOND) ? SRC_SECOND :
                         (mainSrc_q == `MAIN_PRIMARY) ? SRC_PRIMARY : SRC_DCO;
   wire src_t subWant = subSrc_q ? SRC_SECOND : SRC_DCO;
   wire mainLvl = srcLevel(mainCur_q, ctrlClk, secondLvl, auxLvl);
   wire subLvl  = srcLevel(subCur_q, ctrlClk, secondLvl, auxLvl);
   wire mainSwap = ~mainLvl & ~srcLevel(mainWant, ctrlClk, secondLvl, auxLvl);
   wire subSwap  = ~subLvl & ~srcLevel(subWant, ctrlClk, secondLvl, auxLvl);
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         mainCur_q <= SRC_DCO;
         subCur_q  <= SRC_DCO;
      end else begin
         if (mainSwap) mainCur_q <= mainWant;
         if (subSwap) subCur_q <= subWant;
      end
   end

   // Registered outputs
   clocks_t clocks_q;
   logic nmi_q, primEn_q, secEn_q;
   logic [2:0] range3_q;
   wire [2:0] rangeDec = range_q[3] ? 3'h4 : range_q[2] ? 3'h3 :
                         range_q[1] ? 3'h2 : range_q[0] ? 3'h1 : 3'h0;
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         clocks_q <= '0;
         nmi_q    <= 1'b0;
         primEn_q <= 1'b1;
         secEn_q  <= 1'b0;
         range3_q <= 3'h0;
      end else begin
         clocks_q.mainClock    <= mainLvl & ~cpu_clock_off_q;
         clocks_q.subMainClock <= subLvl & ~subDis_q & ~subGen_q;
         clocks_q.auxClock     <= auxLvl;
         clocks_q.auxOutClock  <= auxOut;
         clocks_q.ctrlOscClock <= ctrlClk;
         nmi_q    <= faultFlag_q & intEn_q;
         primEn_q <= primaryEn;
         secEn_q  <= secondEn;
         range3_q <= rangeDec;
      end
   end

   // Read path
   wire [7:0] rdByte =
      (idx == `IDX_MULT)     ? {modCtl_q, multN_q} :
      (idx == `IDX_INT_LOW)  ? {loopDiv_q, range_q, integ_q[1:0]} :
      (idx == `IDX_INT_HIGH) ? integ_q[9:2] :
      (idx == `IDX_CTL0)     ? {prediv_q, speed_q, loadCap_q, secFault_q, hfFault_q, lfFault_q, dcoFault_q} :
      (idx == `IDX_CTL1)     ? {1'b0, subDis_q, secondOff_q, mainSrc_q, subSrc_q, auxDiv_q} :
      (idx == `IDX_INT_EN)   ? {6'h00, intEn_q, 1'b0} :
      (idx == `IDX_INT_FLAG) ? {6'h00, faultFlag_q, 1'b0} :
      (idx == `IDX_OP_MODE)  ? {4'h0, cpu_clock_off_q, crystal_osc_disable_q, subGen_q, loopHalt_q} : 8'h00;
   wire mapped = addrOk & ((idx == `IDX_MULT) | (idx == `IDX_INT_LOW) | (idx == `IDX_INT_HIGH)
                 | (idx == `IDX_CTL0) | (idx == `IDX_CTL1) | (idx == `IDX_INT_EN)
                 | (idx == `IDX_INT_FLAG) | (idx == `IDX_OP_MODE));
   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h00000000;
      end else begin
         pready_q  <= setupAcc;
         pslverr_q <= setupAcc & ~mapped;
         prdata_q  <= (setupAcc & ~apbIn.pwrite & mapped) ? {24'h000000, rdByte} : 32'h00000000;
      end
   end

   assign prdata           = prdata_q;
   assign pready           = pready_q;
   assign pslverr          = pslverr_q;
   assign clocksOut        = clocks_q;
   assign nmiRequest       = nmi_q;
   assign primaryOscEnable = primEn_q;
   assign secondOscEnable  = secEn_q;
   assign crystalSpeed     = speed_q;
   assign loadCap          = loadCap_q;
   assign tapSelect        = tapSel_q;
   assign oscRange         = range3_q;

   property p_faultLatch;
      @(posedge clock) disable iff (!rstN) anyFault |=> faultFlag_q;
   endproperty
   a_faultLatch: assert property (p_faultLatch) else $error("fault flag not latched");
   property p_faultHoldsDco;
      @(posedge clock) disable iff (!rstN)
         (faultFlag_q && mainCur_q == SRC_DCO) |=> (mainCur_q == SRC_DCO);
   endproperty
   a_faultHoldsDco: assert property (p_faultHoldsDco) else $error("main left loop during fault");
   property p_tapClamp;
      @(posedge clock) disable iff (!rstN) tapSel_q <= `TAP_TOP;
   endproperty
   a_tapClamp: assert property (p_tapClamp) else $error("tap above top code");
   property p_haltFreeze;
      @(posedge clock) disable iff (!rstN) (loopHalt_q && !wIntL && !wIntH) |=> $stable(integ_q);
   endproperty
   a_haltFreeze: assert property (p_haltFreeze) else $error("integrator moved while halted");
   property p_stepOne;
      @(posedge clock) disable iff (!rstN) (!wIntL && !wIntH && !auxRise && !lostTick) |=> $stable(integ_q);
   endproperty
   a_stepOne: assert property (p_stepOne) else $error("integrator moved without aux tick");
   property p_intEntry;
      @(posedge clock) disable iff (!rstN)
         interruptEntry |=> (!cpu_clock_off_q && !crystal_osc_disable_q && !subGen_q && loopHalt_q == $past(loopHalt_q) | $past(wMode));
   endproperty
   a_intEntry: assert property (p_intEntry) else $error("interrupt entry mode bits wrong");
   property p_primaryKeep;
      @(posedge clock) disable iff (!rstN) (mainSrc_q == `MAIN_PRIMARY && !cpu_clock_off_q) |=> primEn_q;
   endproperty
   a_primaryKeep: assert property (p_primaryKeep) else $error("primary stopped while feeding main");
   property p_secondKeep;
      @(posedge clock) disable iff (!rstN)
         (subSrc_q && !subDis_q && !wCtl1) |=> ##1 secEn_q;
   endproperty
   a_secondKeep: assert property (p_secondKeep) else $error("second stopped while feeding sub clock");
   property p_grantClears;
      @(posedge clock) disable iff (!rstN) nmiGrant |=> !intEn_q ##1 !nmi_q;
   endproperty
   a_grantClears: assert property (p_grantClears) else $error("enable not cleared on grant");
   property p_dcoFault;
      @(posedge clock) disable iff (!rstN) (tapCode == `TAP_LOWEST) |=> dcoFault_q ##1 faultFlag_q;
   endproperty
   a_dcoFault: assert property (p_dcoFault) else $error("lowest tap without loop fault");
endmodule // fll_clock_generator

// ### dv/crystal_model.sv
// Crystal, second oscillator and raw controlled oscillator model feeding the generator pins
`timescale 1ns/100ps
module crystal_model #(
   parameter int AuxHalf    = 20,
   parameter int SecondHalf = 6,
   parameter int OscHalf    = 4
) (
   input  wire logic             clock,
   input  wire logic             run,
   input  wire logic             primaryEnable,
   input  wire logic             secondEnable,
   input  wire logic             primaryFail,
   output fll_pkg::pin_in_t      pins
);
   import fll_pkg::*;
   // A stopped or failed oscillator parks low, as a dead crystal gives no edges
   wire logic [2:0] running = {run, run & secondEnable, run & primaryEnable & ~primaryFail};
   for (genvar i = 0; i < 3; i++) begin : g_osc
      localparam int Half = (i == 0) ? AuxHalf : (i == 1) ? SecondHalf : OscHalf;
      int   cntQ = 0;
      logic lvlQ = 1'b0;
      always_ff @(posedge clock) begin
         cntQ <= (cntQ >= Half - 1) ? 0 : cntQ + 1;
         if (cntQ >= Half - 1) begin
            lvlQ <= ~lvlQ & running[i];
         end
      end
   end
   assign pins = '{auxCrystal: g_osc[0].lvlQ, secondCrystal: g_osc[1].lvlQ, ctrlOsc: g_osc[2].lvlQ,
                   primaryOk: running[0], secondOk: running[1]};
endmodule // crystal_model

// ### dv/testbench.sv
// Self-checking bench for registers, clock selection, dividers and fault handling
`timescale 1ns/100ps
`include "fll_clock_generator_consts.svh"
module testbench;
   import fll_pkg::*;
   typedef struct { logic [11:0] addr; logic [7:0] data; logic err; } row_t;
   localparam logic [11:0] IntLow  = {3'h0, `IDX_INT_LOW, 2'h0};
   localparam logic [11:0] IntHigh = {3'h0, `IDX_INT_HIGH, 2'h0};
   localparam logic [11:0] Ctl0    = {3'h0, `IDX_CTL0, 2'h0};
   localparam logic [11:0] Ctl1    = {3'h0, `IDX_CTL1, 2'h0};
   localparam logic [11:0] IntEn   = {3'h0, `IDX_INT_EN, 2'h0};
   localparam logic [11:0] IntFlag = {3'h0, `IDX_INT_FLAG, 2'h0};
   localparam logic [11:0] OpMode  = {3'h0, `IDX_OP_MODE, 2'h0};
   // Source periods in system cycles; loop clock is raw oscillator over D = 2
   localparam int AuxP = 40;
   localparam int SecP = 12;
   localparam int DcoP = 16;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   apb_req_t    apbIn = '0;
   logic [31:0] prdata;
   logic        pready, pslverr, nmiRequest, primaryOscEnable, secondOscEnable, crystalSpeed;
   pin_in_t     pinIn;
   clocks_t     clocksOut;
   logic        interruptEntry = 1'b0;
   logic        nmiGrant = 1'b0;
   logic        run = 1'b0;
   logic        primaryFail = 1'b0;
   logic [1:0]  loadCap;
   logic [4:0]  tapSelect;
   logic [2:0]  oscRange;
   logic [7:0]  rdData;
   logic        rdErr;
   logic [9:0]  integ;
   int          per;
   int          cycles = 0;
   int          nMismatch = 0;
   int          totalChecks = 0;
   int          mainP [4] = '{DcoP, DcoP, SecP, AuxP};
   row_t        rows [10] = '{
      '{12'h148, 8'h1F, 1'b0},
      '{12'h140, 8'h40, 1'b0},
      '{12'h144, 8'h00, 1'b0},
      '{12'h14C, 8'h03, 1'b0},
      '{12'h150, 8'h20, 1'b0},
      '{12'h000, 8'h00, 1'b0},
      '{12'h008, 8'h02, 1'b0},
      '{12'h154, 8'h00, 1'b0},
      '{12'h158, 8'h00, 1'b1},
      '{12'h141, 8'h00, 1'b1}
   };

   fll_clock_generator #(.AuxLostCycles(64)) u_fll_clock_generator (
      .clock(clock), .reset_n(reset_n), .apbIn(apbIn), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pinIn(pinIn), .interruptEntry(interruptEntry), .nmiGrant(nmiGrant), .clocksOut(clocksOut),
      .nmiRequest(nmiRequest), .primaryOscEnable(primaryOscEnable), .secondOscEnable(secondOscEnable),
      .crystalSpeed(crystalSpeed), .loadCap(loadCap), .tapSelect(tapSelect), .oscRange(oscRange));
   crystal_model #(.AuxHalf(AuxP / 2), .SecondHalf(SecP / 2), .OscHalf(DcoP / 4)) u_crystal_model (
      .clock(clock), .run(run), .primaryEnable(primaryOscEnable), .secondEnable(secondOscEnable),
      .primaryFail(primaryFail), .pins(pinIn));

   initial begin
      forever #5 clock = ~clock;
   end

   task automatic stopTest();
      if (nMismatch == 0 && totalChecks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         nMismatch++;
         stopTest();
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      totalChecks++;
      if (got !== exp) begin
         nMismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
      totalChecks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         nMismatch++;
         $display("CHECK FAILED %s expected %0h to %0h seen %0h", what, lo, hi, got);
      end
   endtask

   // Holds the request until pready is seen high at a rising edge, then releases it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      apbIn <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
      @(posedge clock);
      apbIn.penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdData = prdata[7:0];
      rdErr = pslverr;
      apbIn <= '0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk("register read", {24'h0, exp}, {24'h0, rdData});
   endtask

   // Reset values of every register and of the configuration ports
   task automatic resetReads();
      foreach (rows[i]) begin
         apb(1'b0, rows[i].addr, 8'h00);
         chk("reset read", {24'h0, rows[i].data}, {24'h0, rdData});
         chk("slave error", {31'h0, rows[i].err}, {31'h0, rdErr});
      end
      chk("reset ports", 14'h2000, {primaryOscEnable, secondOscEnable, crystalSpeed, loadCap, tapSelect,
          oscRange, nmiRequest});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Cycles between the second and third rising edge; the first may follow a switch
   task automatic period(input int k, output int p);
      logic [4:0] v;
      logic       prev = 1'b1;
      int         t = 0;
      int         e = 0;
      int         t2 = 0;
      p = -1;
      while (e < 3 && t < 3000) begin
         @(posedge clock);
         v = clocksOut;
         t++;
         if (v[k] === 1'b1 && prev === 1'b0) begin
            e++;
            t2 = (e == 2) ? t : t2;
            p = (e == 3) ? t - t2 : p;
         end
         prev = v[k];
      end
   endtask

   initial begin
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      cyc(4);
      resetReads();
      run <= 1'b1;
      wr(OpMode, 8'h01);
      wr(IntHigh, 8'h40);
      cyc(100);
      rd(Ctl0, 8'h00);
      chk("tap", 5'd8, tapSelect);
      wr(IntFlag, 8'h00);
      rd(IntFlag, 8'h00);
      for (int i = 0; i < 4; i++) begin
         wr(Ctl1, 8'h20 + 8'(i * 8) + 8'(i % 2 * 4));
         cyc(4);
         chk("second enable", i != 0, secondOscEnable);
         // A starting oscillator is flagged faulty for a few cycles; clear the latch so the chosen source runs
         wr(IntFlag, 8'h00);
         cyc(100);
         period(4, per);
         chk("main period", mainP[i], per);
         period(3, per);
         chk("sub period", (i % 2 == 1) ? SecP : DcoP, per);
      end
      for (int d = 0; d < 4; d++) begin
         wr(Ctl1, 8'h20 + 8'(d));
         period(1, per);
         chk("aux out period", AuxP << d, per);
      end
      wr(Ctl1, 8'h38);
      wr(OpMode, 8'h05);
      cyc(3);
      chk("primary enable", 1'b1, primaryOscEnable);
      wr(OpMode, 8'h0F);
      wr(Ctl1, 8'h30);
      cyc(3);
      chk("enables off", 2'b00, {primaryOscEnable, secondOscEnable});
      interruptEntry <= 1'b1;
      @(posedge clock);
      interruptEntry <= 1'b0;
      rd(OpMode, 8'h01);
      cyc(3);
      chk("enables on", 2'b11, {primaryOscEnable, secondOscEnable});
      wr(Ctl1, 8'h64);
      cyc(3);
      chk("second enable", 1'b0, secondOscEnable);
      wr(Ctl1, 8'h38);
      wr(IntFlag, 8'h00);
      wr(IntEn, 8'h02);
      cyc(2);
      chk("nmi", 1'b0, nmiRequest);
      primaryFail <= 1'b1;
      cyc(20);
      rd(Ctl0, 8'h02);
      chk("nmi", 1'b1, nmiRequest);
      period(4, per);
      chk("forced main period", DcoP, per);
      rd(Ctl1, 8'h38);
      primaryFail <= 1'b0;
      cyc(20);
      rd(Ctl0, 8'h00);
      rd(IntFlag, 8'h02);
      nmiGrant <= 1'b1;
      @(posedge clock);
      nmiGrant <= 1'b0;
      rd(IntEn, 8'h00);
      wr(IntFlag, 8'h00);
      cyc(100);
      period(4, per);
      chk("restored main period", AuxP, per);
      wr(IntHigh, 8'hF8);
      cyc(30);
      chk("tap", 5'd28, tapSelect);
      rd(Ctl0, 8'h01);
      wr(IntLow, 8'h40);
      wr(IntHigh, 8'h00);
      cyc(30);
      chk("tap", 5'd0, tapSelect);
      wr(IntHigh, 8'h40);
      wr(OpMode, 8'h00);
      cyc(400);
      wr(OpMode, 8'h01);
      apb(1'b0, IntHigh, 8'h00);
      integ[9:2] = rdData;
      apb(1'b0, IntLow, 8'h00);
      integ[1:0] = rdData[1:0];
      chk_rng("integrator", 10'h107, 10'h10D, integ);
      cyc(200);
      rd(IntHigh, integ[9:2]);
      for (int i = 0; i < 4; i++) begin
         wr(Ctl0, 8'(i * 16) + 8'(i % 2 * 64));
         cyc(2);
         chk("speed and load cap", {1'(i % 2), 2'(i)}, {crystalSpeed, loadCap});
      end
      for (int r = 0; r < 16; r++) begin
         wr(IntLow, 8'h40 + 8'(r * 4));
         cyc(2);
         chk("range", (r >= 8) ? 4 : (r >= 4) ? 3 : (r >= 2) ? 2 : r, oscRange);
      end
      // Code 8 of 32 picks the upper tap on 8 of every 32 oscillator periods of 8 cycles
      wr(12'h148, 8'h9F);
      wr(IntHigh, 8'h42);
      cyc(20);
      per = 0;
      repeat (32 * 8) begin
         @(posedge clock);
         per += (tapSelect === 5'd9);
      end
      chk("upper tap cycles", 8 * 8, per);
      wr(12'h148, 8'h1F);
      cyc(20);
      chk("unmodulated tap", 5'd8, tapSelect);
      wr(Ctl0, 8'h80);
      period(0, per);
      chk("bypass period", DcoP / 2, per);
      wr(Ctl0, 8'h00);
      wr(IntLow, 8'hC0);
      period(0, per);
      chk("loop divider period", DcoP * 4, per);
      // Soft clear in mid-run; crystals park low first so no false edge follows release
      run <= 1'b0;
      reset_n <= 1'b0;
      cyc(24);
      reset_n <= 1'b1;
      cyc(4);
      resetReads();
      stopTest();
   end
endmodule // testbench
